/* File: hdl/meter_spi_params.svh */
// constants for the metering serial port: frame layout, control field positions, timing
// assumes a 125 MHz system clock; included by bare name
`ifndef METER_SPI_PARAMS_SVH
`define METER_SPI_PARAMS_SVH

`define CLK_PERIOD_NS    8
`define FRAME_BITS       6'h20
`define ADDR_DONE_BITS   6'h10
`define CNT_SAT          6'h3F
`define TYPE_BIT         31
`define ADDR_LSB         16
`define ADDR_MSB         25
`define DC_DIV_LSB       0
`define DC_DIV_MSB       3
`define DC_DRV_BIT       4
`define DC_IDLE_BIT      5
`define DC_WIDTH_LSB     6
`define DC_WIDTH_MSB     7
`define DC_EN_MSB        15
`define NUM_CH           7
`define SAMPLE_BITS      32
`define PM_RANGE_LO      10'h014
`define PM_RANGE_HI      10'h01D
`define PM_SPECIAL_0     10'h000
`define PM_SPECIAL_1     10'h001
`define PM_SPECIAL_2     10'h003
`define PM_SPECIAL_3     10'h007
`define PM_SPECIAL_4     10'h00E
`define PM_SPECIAL_5     10'h00F
`define GAP_HALVES       7'h04
`define WIDTH_16         6'h10
`define WIDTH_24         6'h18
`define WIDTH_32         6'h20
`define LAST_DATA_RST    16'h0000

`endif

/* File: hdl/meter_spi_pkg.sv */
// types shared by the serial port and its bit serializer
// no constants here; they live in the params header
package meter_spi_pkg;
   typedef enum {M_IDLE, M_WAIT, M_SEND, M_GAP} master_state_e;
   typedef logic [3:0] chan_t;
   typedef logic [5:0] bitcnt_t;
endpackage : meter_spi_pkg

/* File: hdl/sample_link_if.sv */
// carrier between the dump sequencer and the bit serializer
// both ends sit on the same system clock
`timescale 1ns/1ps
interface sample_link_if;
   logic                  start;
   logic [31:0]           word;
   meter_spi_pkg::bitcnt_t nbits;
   logic [3:0]            div;
   logic                  drive;
   logic                  idle;
   logic                  busy;
   logic                  sclk;
   logic                  sdo;
   modport seq (output start, word, nbits, div, drive, idle, input busy, sclk, sdo);
   modport ser (input start, word, nbits, div, drive, idle, output busy, sclk, sdo);
endinterface : sample_link_if

/* File: hdl/bit_serializer.sv */
// shifts one left-aligned sample out MSB first with a divided serial clock
// assumes start is only raised while busy is low
`timescale 1ns/1ps
`include "meter_spi_params.svh"
module bit_serializer (
   input wire logic    clk,
   input wire logic    rst_n,
   sample_link_if.ser  lnk
);
   logic [4:0]  half_cnt_reg;
   logic        phase_reg;
   logic        busy_reg;
   logic        sdo_reg;
   logic [31:0] shift_reg;
   logic [5:0]  bits_left_reg;
   logic        half_end;

   // half period lasts div+1 clocks, so a full period is div*2+2
   assign half_end = (half_cnt_reg == {1'b0, lnk.div});
   assign lnk.busy = busy_reg;
   assign lnk.sclk = busy_reg ? (lnk.idle ^ phase_reg) : lnk.idle;
   assign lnk.sdo  = sdo_reg;

   // drive=0: data set before the first edge; drive=1: data changes on the first edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         half_cnt_reg  <= 5'h00;
         phase_reg     <= 1'b0;
         busy_reg      <= 1'b0;
         sdo_reg       <= 1'b0;
         shift_reg     <= 32'h0000_0000;
         bits_left_reg <= 6'h00;
      end else if (lnk.start && !busy_reg) begin
         busy_reg      <= 1'b1;
         half_cnt_reg  <= 5'h00;
         phase_reg     <= 1'b0;
         bits_left_reg <= lnk.nbits;
         sdo_reg       <= lnk.drive ? sdo_reg : lnk.word[31];
         shift_reg     <= lnk.drive ? lnk.word : {lnk.word[30:0], 1'b0};
      end else if (busy_reg) begin
         half_cnt_reg <= half_end ? 5'h00 : half_cnt_reg + 5'h01;
         if (half_end) begin
            phase_reg <= ~phase_reg;
            if (!phase_reg && lnk.drive) begin
               sdo_reg   <= shift_reg[31];
               shift_reg <= {shift_reg[30:0], 1'b0};
            end else if (phase_reg) begin
               bits_left_reg <= bits_left_reg - 6'h01;
               busy_reg      <= (bits_left_reg != 6'h01);
               if (!lnk.drive) begin
                  sdo_reg   <= shift_reg[31];
                  shift_reg <= {shift_reg[30:0], 1'b0};
               end
            end
         end
      end
   end

   a_half_period_len : assert property (@(posedge clk) disable iff (!rst_n)
      busy_reg && !half_end |=> ($past(half_cnt_reg) + 5'h01 == half_cnt_reg) || !busy_reg)
      else $error("serial clock half period counter skipped");
   a_idle_when_free : assert property (@(posedge clk) disable iff (!rst_n)
      !busy_reg |-> lnk.sclk == lnk.idle && !phase_reg)
      else $error("serial clock left idle level while not sending");
endmodule : bit_serializer

/* File: hdl/meter_spi_port.sv */
// host serial port of a metering device: register slave or sample dump master
// assumes all pins synchronous to CLK; register file sits outside and answers reads in-cycle
//
// Overview of operation
// - dump request low: four-wire register slave; high: sample dump master.
// - serial clock pin is driven in master mode, an input in slave mode.
// - chip select pin is driven in master mode, an input in slave mode.
// - slave captures SDI on rising clock edges, changes SDO on falling edges.
// - first frame bit selects access: 1 read, 0 write.
// - 15-bit address follows, low 10 decoded; then a 16-bit data word.
// - one chip-select low period is one transaction on one register.
// - write commits at chip select rise, only after exactly 32 clocks.
// - read fetches after 16 clocks, shifts it out and updates last data.
// - clear-on-read happens only after last transfer data is updated.
// - partial-measurement mode allows only 14H-1DH and a few special addresses.
// - no register access while the port is master.
// - dump request rising edge starts streaming samples at divided clock rate.
// - dump request falling ends the dump after the current sample.
// - serial clock is system clock over divider times two plus two.
// - enabled channels go out in order I4 I1 V1 I2 V2 I3 V3.
// - samples go MSB first with the width field's bit count.
// - waiting for samples, chip select high and clock idle for two periods.
// - drive-select picks whether the first clock edge samples or drives.
`timescale 1ns/1ps
`include "meter_spi_params.svh"
module meter_spi_port (
   input  wire logic         CLK,
   input  wire logic         RST_N,
   input  wire logic         DUMP_REQ,
   input  wire logic         PARTIAL_MODE,
   input  wire logic [15:0]  DUMP_CONTROL,
   input  wire logic         SCLK_I,
   output wire logic         SCLK_O,
   output wire logic         SCLK_OE_N,
   input  wire logic         CS_N_I,
   output wire logic         CS_N_O,
   output wire logic         CS_N_OE_N,
   input  wire logic         SDI,
   output wire logic         SDO_O,
   output wire logic         SDO_OE_N,
   output wire logic [9:0]   REG_ADDR,
   output wire logic         REG_RD_EN,
   input  wire logic [15:0]  REG_RD_DATA,
   output wire logic         REG_RD_CLEAR,
   output wire logic         REG_WR_EN,
   output wire logic [15:0]  REG_WR_DATA,
   output wire logic [15:0]  LAST_TRANSFER_DATA,
   output wire logic         ACCESS_DENIED,
   input  wire logic         SAMPLE_VALID,
   input  wire logic [223:0] SAMPLE_SET,
   output wire logic         MASTER_ACTIVE
);
   meter_spi_pkg::master_state_e state_reg;
   logic        req_s1_reg, req_s2_reg, req_prev_reg;
   logic        sclk_prev_reg, cs_prev_reg;
   logic [31:0] rx_shift_reg;
   logic [5:0]  rx_cnt_reg;
   logic [15:0] tx_shift_reg, last_data_reg;
   logic        sdo_reg, clear_reg, denied_reg, cs_n_reg, issued_reg, pend_reg;
   logic [3:0]  chan_reg;
   logic [6:0]  gap_cnt_reg;
   logic [31:0] store_reg [`NUM_CH];
   logic [6:0]  en_ord;

   sample_link_if lnk ();

   // true when the address may be reached in the current power mode
   function automatic logic access_ok(input logic [9:0] a, input logic partial);
      access_ok = !partial || (a >= `PM_RANGE_LO && a <= `PM_RANGE_HI) ||
                  a == `PM_SPECIAL_0 || a == `PM_SPECIAL_1 || a == `PM_SPECIAL_2 ||
                  a == `PM_SPECIAL_3 || a == `PM_SPECIAL_4 || a == `PM_SPECIAL_5;
   endfunction : access_ok

   // first enabled channel at or after position 'from'; returns 7 when none
   function automatic meter_spi_pkg::chan_t next_ch(input logic [6:0] en, input logic [3:0] from);
      next_ch = 4'h7;
      for (int k = 6; k >= 0; k--) begin
         if (en[k] && 4'(k) >= from) next_ch = 4'(k);
      end
   endfunction : next_ch

   // slave decode; master phases and the sync path gate every register strobe
   wire slave_mode = (state_reg == meter_spi_pkg::M_IDLE) && !req_s2_reg;
   wire cs_low     = slave_mode && !CS_N_I;
   wire s_rise     = cs_low && SCLK_I && !sclk_prev_reg;
   wire s_fall     = cs_low && !SCLK_I && sclk_prev_reg;
   wire cs_rise    = slave_mode && CS_N_I && !cs_prev_reg;
   wire [9:0] rd_addr = {rx_shift_reg[8:0], SDI};
   wire [9:0] wr_addr = rx_shift_reg[`ADDR_MSB:`ADDR_LSB];
   wire rd_hit  = s_rise && rx_cnt_reg == `ADDR_DONE_BITS - 6'h01 && rx_shift_reg[14];
   wire wr_hit  = cs_rise && rx_cnt_reg == `FRAME_BITS && !rx_shift_reg[`TYPE_BIT];
   wire rd_ok   = access_ok(rd_addr, PARTIAL_MODE);
   wire wr_ok   = access_ok(wr_addr, PARTIAL_MODE);

   assign REG_RD_EN    = rd_hit && rd_ok;
   assign REG_WR_EN    = wr_hit && wr_ok;
   assign REG_ADDR     = wr_hit ? wr_addr : rd_addr;
   assign REG_WR_DATA  = rx_shift_reg[15:0];
   assign REG_RD_CLEAR = clear_reg;
   assign LAST_TRANSFER_DATA = last_data_reg;
   assign ACCESS_DENIED      = denied_reg;

   // pin directions: master owns clock and select, slave drives SDO only when selected
   assign MASTER_ACTIVE = !slave_mode;
   assign SCLK_OE_N = slave_mode;
   assign CS_N_OE_N = slave_mode;
   assign SCLK_O    = slave_mode ? 1'b0 : lnk.sclk;
   assign CS_N_O    = cs_n_reg;
   assign SDO_O     = slave_mode ? sdo_reg : lnk.sdo;
   assign SDO_OE_N  = slave_mode ? CS_N_I : 1'b0;

   // pin sampling and dump request synchroniser
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         req_s1_reg    <= 1'b0;
         req_s2_reg    <= 1'b0;
         req_prev_reg  <= 1'b0;
         sclk_prev_reg <= 1'b0;
         cs_prev_reg   <= 1'b1;
      end else begin
         req_s1_reg    <= DUMP_REQ;
         req_s2_reg    <= req_s1_reg;
         req_prev_reg  <= req_s2_reg;
         sclk_prev_reg <= SCLK_I;
         cs_prev_reg   <= CS_N_I;
      end
   end

   // slave shifter; the count saturates so an overlong frame never looks like 32
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         rx_shift_reg  <= 32'h0000_0000;
         rx_cnt_reg    <= 6'h00;
         tx_shift_reg  <= 16'h0000;
         sdo_reg       <= 1'b0;
         last_data_reg <= `LAST_DATA_RST;
         clear_reg     <= 1'b0;
         denied_reg    <= 1'b0;
      end else begin
         clear_reg  <= REG_RD_EN;
         denied_reg <= (rd_hit && !rd_ok) || (wr_hit && !wr_ok);
         if (!cs_low) begin
            rx_cnt_reg <= 6'h00;
         end else if (s_rise) begin
            rx_shift_reg <= {rx_shift_reg[30:0], SDI};
            rx_cnt_reg   <= (rx_cnt_reg == `CNT_SAT) ? rx_cnt_reg : rx_cnt_reg + 6'h01;
         end
         if (rd_hit) begin
            tx_shift_reg  <= rd_ok ? REG_RD_DATA : 16'h0000;
            last_data_reg <= rd_ok ? REG_RD_DATA : 16'h0000;
         end else if (s_fall && rx_cnt_reg >= `ADDR_DONE_BITS) begin
            sdo_reg      <= tx_shift_reg[15];
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
         end
      end
   end

   // channel enables in send order, and the sample store
   genvar g;
   generate
      for (g = 0; g < `NUM_CH; g++) begin : g_ch
         assign en_ord[g] = DUMP_CONTROL[`DC_EN_MSB - g];
         always_ff @(posedge CLK or negedge RST_N) begin
            if (!RST_N) store_reg[g] <= 32'h0000_0000;
            else if (SAMPLE_VALID) store_reg[g] <= SAMPLE_SET[g*`SAMPLE_BITS +: `SAMPLE_BITS];
         end
      end
   endgenerate

   // master sequencing wires
   wire [1:0] wsel      = DUMP_CONTROL[`DC_WIDTH_MSB:`DC_WIDTH_LSB];
   wire [6:0] gap_last  = 7'((7'({3'h0, DUMP_CONTROL[`DC_DIV_MSB:0]}) + 7'h01) * `GAP_HALVES
                             - 7'h01);
   wire [3:0] first_ch  = next_ch(en_ord, 4'h0);
   wire [3:0] after_ch  = next_ch(en_ord, chan_reg + 4'h1);
   wire       word_done = issued_reg && !lnk.busy;
   assign lnk.start = (state_reg == meter_spi_pkg::M_SEND) && !issued_reg;
   assign lnk.word  = store_reg[chan_reg[2:0]];
   assign lnk.nbits = (wsel == 2'h0) ? `WIDTH_16 : (wsel == 2'h1) ? `WIDTH_24 : `WIDTH_32;
   assign lnk.div   = DUMP_CONTROL[`DC_DIV_MSB:`DC_DIV_LSB];
   assign lnk.drive = DUMP_CONTROL[`DC_DRV_BIT];
   assign lnk.idle  = DUMP_CONTROL[`DC_IDLE_BIT];

   bit_serializer u_ser (
      .clk   (CLK),
      .rst_n (RST_N),
      .lnk   (lnk)
   );

   // dump state machine; a fresh sample set while pending just overwrites it
   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         state_reg   <= meter_spi_pkg::M_IDLE;
         cs_n_reg    <= 1'b1;
         issued_reg  <= 1'b0;
         pend_reg    <= 1'b0;
         chan_reg    <= 4'h0;
         gap_cnt_reg <= 7'h00;
      end else begin
         if (SAMPLE_VALID) pend_reg <= 1'b1;                               // set beats clear
         else if (state_reg == meter_spi_pkg::M_WAIT && pend_reg) pend_reg <= 1'b0;
         unique case (state_reg)
            meter_spi_pkg::M_IDLE: begin
               if (req_s2_reg && !req_prev_reg) state_reg <= meter_spi_pkg::M_WAIT;
            end
            meter_spi_pkg::M_WAIT: begin
               if (!req_s2_reg) begin
                  state_reg <= meter_spi_pkg::M_IDLE;
               end else if (pend_reg && first_ch != 4'h7) begin
                  chan_reg   <= first_ch;
                  issued_reg <= 1'b0;
                  cs_n_reg   <= 1'b0;
                  state_reg  <= meter_spi_pkg::M_SEND;
               end
            end
            meter_spi_pkg::M_SEND: begin
               if (!issued_reg) begin
                  issued_reg <= 1'b1;
               end else if (word_done) begin
                  issued_reg <= 1'b0;
                  if (!req_s2_reg) begin
                     cs_n_reg  <= 1'b1;
                     state_reg <= meter_spi_pkg::M_IDLE;
                  end else if (after_ch != 4'h7) begin
                     chan_reg <= after_ch;
                  end else begin
                     cs_n_reg    <= 1'b1;
                     gap_cnt_reg <= 7'h00;
                     state_reg   <= meter_spi_pkg::M_GAP;
                  end
               end
            end
            meter_spi_pkg::M_GAP: begin
               gap_cnt_reg <= gap_cnt_reg + 7'h01;
               if (gap_cnt_reg >= gap_last) state_reg <= meter_spi_pkg::M_WAIT;
            end
         endcase
      end
   end

   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   a_req_sync_lag : assert property ($rose(req_s2_reg) |-> $past(DUMP_REQ, 2))
      else $error("dump request edge used without two-stage sync");
   a_clock_dir : assert property (MASTER_ACTIVE |-> !SCLK_OE_N ##0 !SDO_OE_N)
      else $error("master mode without clock drive");
   a_select_dir : assert property (slave_mode |-> CS_N_OE_N && CS_N_O)
      else $error("chip select driven in slave mode");
   a_sdi_capture : assert property (s_rise |=> rx_shift_reg[0] == $past(SDI))
      else $error("SDI not captured on rising clock edge");
   a_write_commit : assert property (REG_WR_EN |-> $rose(CS_N_I) && rx_cnt_reg == 6'h20)
      else $error("write committed without a full 32-clock frame");
   a_read_fetch : assert property (REG_RD_EN |=> last_data_reg == $past(REG_RD_DATA))
      else $error("last transfer data not loaded by read");
   a_clear_after : assert property (REG_RD_CLEAR |-> $past(REG_RD_EN) &&
                                    LAST_TRANSFER_DATA == $past(REG_RD_DATA))
      else $error("clear-on-read before last transfer data update");
   a_partial_gate : assert property ((REG_RD_EN || REG_WR_EN) |->
                                     access_ok(REG_ADDR, PARTIAL_MODE))
      else $error("register reached outside partial-mode window");
   a_master_reject : assert property (MASTER_ACTIVE |-> !REG_RD_EN && !REG_WR_EN)
      else $error("register access while master");
   a_dump_start : assert property (state_reg == meter_spi_pkg::M_IDLE && req_s2_reg &&
                                   !req_prev_reg |=> state_reg == meter_spi_pkg::M_WAIT)
      else $error("dump did not start on request rise");
   a_stop_finish : assert property (state_reg == meter_spi_pkg::M_SEND && lnk.busy |=>
                                    state_reg == meter_spi_pkg::M_SEND)
      else $error("sample cut short");
   a_gap_idle : assert property (state_reg == meter_spi_pkg::M_GAP |-> CS_N_O &&
                                 SCLK_O == DUMP_CONTROL[`DC_IDLE_BIT])
      else $error("gap without idle clock and high select");

   c_write : cover property (REG_WR_EN);
   c_read_clear : cover property (REG_RD_CLEAR);
   c_gap : cover property (state_reg == meter_spi_pkg::M_GAP ##1 state_reg == meter_spi_pkg::M_WAIT);
   c_stop : cover property ($fell(req_s2_reg) && state_reg == meter_spi_pkg::M_SEND);
endmodule : meter_spi_port

/* File: testbench/sample_receiver.sv */
// behavioural receiver on the dump side of the serial port
// drive select 0: data taken on the edge leaving idle; 1: on the edge returning to idle
`timescale 1ns/1ps
module sample_receiver (
   input  wire logic        clk,
   input  wire logic        sclk,
   input  wire logic        cs_n,
   input  wire logic        sdo,
   input  wire logic        idle_lvl,
   input  wire logic        drive,
   output logic      [31:0] rx_word,
   output logic      [5:0]  rx_bits,
   output logic      [7:0]  edge_gap
);
   logic       sclk_q = 1'b0;
   logic [7:0] gap_cnt = 8'h00;
   wire        take_edge;

   // the sampling edge is the first one of a period, or the second when the device drives on the first
   assign take_edge = drive ? (sclk_q != idle_lvl && sclk == idle_lvl)
                            : (sclk_q == idle_lvl && sclk != idle_lvl);

   initial begin
      rx_word = 32'h00000000;
      rx_bits = 6'h00;
      edge_gap = 8'h00;
   end

   // oversampled edge finder; the gap counts system clocks between sampling edges
   always @(posedge clk) begin
      sclk_q <= sclk;
      gap_cnt <= gap_cnt + 8'h01;
      if (!cs_n && take_edge) begin
         rx_word <= {rx_word[30:0], sdo};
         rx_bits <= rx_bits + 6'h01;
         edge_gap <= gap_cnt + 8'h01;
         gap_cnt <= 8'h00;
      end
   end
endmodule : sample_receiver

/* File: testbench/meter_spi_sample_dump_port_bench.sv */
// self-checking bench: host frames, partial-mode window and two sample dumps
// assumes the register file answers in-cycle; it is modelled here by address echo
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin err_total++; \
   $display("mismatch at %0t: got %0h expected %0h", $time, (got), (exp)); end end
module meter_spi_sample_dump_port_bench;
   logic         clk, rst_n, dump_req, partial_mode, host_sclk, host_cs_n, sdi, sample_valid;
   logic [15:0]  dump_control;
   logic [223:0] sample_set;
   wire logic    sclk_o, sclk_oe_n, cs_n_o, cs_n_oe_n, sdo_o, sdo_oe_n, sclk_pin, cs_pin;
   wire logic    reg_rd_en, reg_rd_clear, reg_wr_en, access_denied, master_active;
   wire logic [9:0]  reg_addr;
   wire logic [15:0] reg_wr_data, last_data, reg_rd_data;
   logic [31:0]  rx_word;
   logic [5:0]   rx_bits;
   logic [7:0]   edge_gap;
   logic [9:0]   wr_addr_q, rd_addr_q;
   logic [15:0]  wr_data_q;
   logic         rd_en_q = 1'b0;
   int           err_total = 0, n_checks = 0, wr_cnt = 0, rd_cnt = 0, den_cnt = 0, bad_clr = 0;
   logic [9:0]   pm_ok [8] = '{10'h014, 10'h01D, 10'h000, 10'h001, 10'h003, 10'h007, 10'h00E,
                               10'h00F};
   logic [9:0]   pm_no [4] = '{10'h013, 10'h01E, 10'h002, 10'h3FF};

   // pins resolve from the enables; the register file echoes its address
   assign sclk_pin = sclk_oe_n ? host_sclk : sclk_o;
   assign cs_pin = cs_n_oe_n ? host_cs_n : cs_n_o;
   assign reg_rd_data = {6'h2B, reg_addr};

   meter_spi_port DUT (.CLK(clk), .RST_N(rst_n), .DUMP_REQ(dump_req),
      .PARTIAL_MODE(partial_mode), .DUMP_CONTROL(dump_control), .SCLK_I(sclk_pin),
      .SCLK_O(sclk_o), .SCLK_OE_N(sclk_oe_n), .CS_N_I(cs_pin), .CS_N_O(cs_n_o),
      .CS_N_OE_N(cs_n_oe_n), .SDI(sdi), .SDO_O(sdo_o), .SDO_OE_N(sdo_oe_n),
      .REG_ADDR(reg_addr), .REG_RD_EN(reg_rd_en), .REG_RD_DATA(reg_rd_data),
      .REG_RD_CLEAR(reg_rd_clear), .REG_WR_EN(reg_wr_en), .REG_WR_DATA(reg_wr_data),
      .LAST_TRANSFER_DATA(last_data), .ACCESS_DENIED(access_denied),
      .SAMPLE_VALID(sample_valid), .SAMPLE_SET(sample_set), .MASTER_ACTIVE(master_active));

   // receiver listens only while the device owns the select line
   sample_receiver receiver (.clk(clk), .sclk(sclk_pin), .cs_n(cs_n_oe_n | cs_pin),
      .sdo(sdo_o), .idle_lvl(dump_control[5]), .drive(dump_control[4]),
      .rx_word(rx_word), .rx_bits(rx_bits),
      .edge_gap(edge_gap));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   // strobe monitor; a clear pulse must trail the read strobe by exactly one cycle
   always @(posedge clk) begin
      rd_en_q <= reg_rd_en;
      if (rst_n && reg_rd_clear !== rd_en_q) bad_clr++;
      if (reg_wr_en === 1'b1) begin
         wr_cnt++;
         wr_addr_q <= reg_addr;
         wr_data_q <= reg_wr_data;
      end
      if (reg_rd_en === 1'b1) begin
         rd_cnt++;
         rd_addr_q <= reg_addr;
      end
      if (access_denied === 1'b1) den_cnt++;
   end

   task automatic test_done();
      $display("comparisons %0d, mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : test_done

   task automatic ticks(input int n);
      repeat (n) @(negedge clk);
   endtask : ticks

   // one host frame; each serial clock level lasts four system clocks, well over the minimum
   task automatic spi_frame(input logic [31:0] w, input int nclk, output logic [15:0] rd);
      rd = 16'h0000;
      host_cs_n = 1'b0;
      ticks(4);
      for (int i = 0; i < nclk; i++) begin
         sdi = w[31-i];
         ticks(4);
         host_sclk = 1'b1;
         if (i >= 16) rd = {rd[14:0], sdo_oe_n ? 1'bx : sdo_o};
         ticks(4);
         host_sclk = 1'b0;
      end
      ticks(4);
      host_cs_n = 1'b1;
      sdi = ~sdi;
      ticks(8);
   endtask : spi_frame

   // exact and short writes, then the partial-mode window on writes
   task automatic write_check();
      logic [15:0] rd;
      int n, d;
      n = wr_cnt;
      d = den_cnt;
      spi_frame({1'b0, 5'h1F, 10'h2C5, 16'hB7E1}, 32, rd);
      `CHK(wr_cnt, n + 1)
      `CHK(wr_addr_q, 10'h2C5)
      `CHK(wr_data_q, 16'hB7E1)
      spi_frame({1'b0, 5'h00, 10'h0A3, 16'h1234}, 31, rd);
      `CHK(wr_cnt, n + 1)
      partial_mode = 1'b1;
      spi_frame({1'b0, 5'h00, 10'h050, 16'h4321}, 32, rd);
      `CHK(wr_cnt, n + 1)
      `CHK(den_cnt, d + 1)
      spi_frame({1'b0, 5'h00, 10'h018, 16'h8001}, 32, rd);
      `CHK(wr_cnt, n + 2)
      partial_mode = 1'b0;
   endtask : write_check

   // a refused read returns zero both on the line and in the last-transfer word
   task automatic read_check(input logic [9:0] a, input logic pm, input logic ok);
      logic [15:0] rd, exp;
      int r, d;
      r = rd_cnt;
      d = den_cnt;
      partial_mode = pm;
      exp = ok ? {6'h2B, a} : 16'h0000;
      spi_frame({1'b1, 5'h15, a, 16'h0000}, 32, rd);
      `CHK(rd, exp)
      `CHK(last_data, exp)
      `CHK(rd_cnt, r + (ok ? 1 : 0))
      `CHK(den_cnt, d + (ok ? 0 : 1))
      `CHK(bad_clr, 0)
      if (ok) `CHK(rd_addr_q, a)
      partial_mode = 1'b0;
   endtask : read_check

   // one dump: a set of nb bits, then a stop while the next set's first wb-bit word is out
   task automatic dump_check(input logic [15:0] ctrl, input logic [223:0] set, input int nb,
                             input int wb, input logic [31:0] exp, input logic [7:0] gap);
      int k, acc;
      logic [5:0] b0;
      b0 = rx_bits;
      acc = rd_cnt + wr_cnt;
      dump_control = ctrl;
      dump_req = 1'b1;
      ticks(8);
      `CHK(master_active, 1'b1)
      `CHK(sclk_oe_n, 1'b0)
      `CHK(cs_n_oe_n, 1'b0)
      sample_set = set;
      sample_valid = 1'b1;
      ticks(1);
      sample_valid = 1'b0;
      for (k = 0; k < 2000 && !(rx_bits == 6'(b0 + nb) && cs_n_o === 1'b1); k++) ticks(1);
      if (k == 2000) begin
         err_total++;
         test_done();
      end
      `CHK(rx_word << (32 - nb), exp)
      `CHK(edge_gap, gap)
      sample_valid = 1'b1;
      ticks(1);
      sample_valid = 1'b0;
      // select stays high for two serial clock periods after the set
      for (k = 0; k < 4 * (ctrl[3:0] + 1) - 1; k++) begin
         `CHK({cs_n_o, sclk_o}, {1'b1, ctrl[5]})
         ticks(1);
      end
      ticks(20);
      dump_req = 1'b0;
      for (k = 0; k < 2000 && master_active !== 1'b0; k++) ticks(1);
      if (k == 2000) begin
         err_total++;
         test_done();
      end
      `CHK(rx_bits, 6'(b0 + nb + wb))
      `CHK(sclk_oe_n, 1'b1)
      `CHK(rd_cnt + wr_cnt, acc)
   endtask : dump_check

   initial begin
      rst_n = 1'b0;
      dump_req = 1'b0;
      partial_mode = 1'b0;
      host_sclk = 1'b0;
      host_cs_n = 1'b1;
      sdi = 1'b0;
      sample_valid = 1'b0;
      dump_control = 16'h0000;
      sample_set = '0;
      ticks(8);
      rst_n = 1'b1;
      ticks(2);
      write_check();
      read_check(10'h3A7, 1'b0, 1'b1);
      foreach (pm_ok[i]) read_check(pm_ok[i], 1'b1, 1'b1);
      foreach (pm_no[i]) read_check(pm_no[i], 1'b1, 1'b0);
      // I4 and V1 enabled, 16 bits, divider 1, device drives on the second edge, idle low
      dump_check(16'hA001, 224'({32'h3C962222, 32'hFFFF0000, 32'hA5C31111}), 32, 16,
                 32'hA5C33C96, 8'h04);
      // V3 only, 24 bits, divider 0, device drives on the first edge, idle high
      dump_check(16'h0270, {32'h5AC3E781, 192'h0}, 24, 24, 32'h5AC3E700, 8'h02);
      test_done();
   end
endmodule : meter_spi_sample_dump_port_bench
